// [verilog/baud_gen_pkg.sv]
// Purpose: shared constants for the bit rate divider
// Assumes: 8-bit register port, word index addressing
// Notes:   offsets are register indices on the plain port
package baud_gen_pkg;

  localparam int          ADDR_W         = 3;
  localparam int          DATA_W         = 8;
  localparam int          DIV_W          = 16;
  localparam int          NUM_STAGES     = 3;

  // register indices
  localparam logic [2:0]  OFS_DIV_LOW    = 3'h0;
  localparam logic [2:0]  OFS_DIV_HIGH   = 3'h1;
  localparam logic [2:0]  OFS_SAMPLE_SEL = 3'h2;
  localparam logic [2:0]  OFS_PRE_EXP    = 3'h3;
  localparam logic [2:0]  OFS_PRE_FRAC   = 3'h4;
  localparam logic [2:0]  OFS_CONTROL    = 3'h5;
  localparam logic [2:0]  OFS_STATUS     = 3'h6;
  localparam logic [2:0]  OFS_BAUD_COUNT = 3'h7;

  // values after reset
  localparam logic [7:0]  RST_DIV_LOW    = 8'h01;
  localparam logic [7:0]  RST_DIV_HIGH   = 8'h00;
  localparam logic [3:0]  RST_SAMPLE_SEL = 4'h0;
  localparam logic [7:0]  RST_PRE_EXP    = 8'h01;
  localparam logic [2:0]  RST_PRE_FRAC   = 3'h0;
  localparam logic        RST_ENABLE     = 1'b1;

  // field limits and arithmetic bases
  localparam logic [4:0]  SAMPLE_BASE    = 5'h10;
  localparam logic [3:0]  SAMPLE_SEL_MAX = 4'hC;
  localparam logic [7:0]  PRE_EXP_ONE    = 8'h01;
  localparam logic [7:0]  PRE_EXP_TWO    = 8'h02;
  localparam int          DIV_HIGH_SHIFT = 8;

  // control and status bit positions
  localparam int          CTL_ENABLE_BIT = 0;
  localparam int          STS_RUN_BIT    = 0;
  localparam int          STS_SEL_BIT    = 1;
  localparam int          STS_EXP_BIT    = 2;
  localparam int          STS_ZERO_BIT   = 3;

  // stage indices of the divider chain
  localparam int          STG_DIVISOR    = 0;
  localparam int          STG_EXPONENT   = 1;
  localparam int          STG_SAMPLE     = 2;

endpackage

// [verilog/stage_if.sv]
// Purpose: link between chain control and one counting stage
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/100ps
interface stage_if;
  logic        step;
  logic        restart;
  logic [15:0] reload_val;
  logic        tick;

  modport ctl (output step, output restart, output reload_val, input tick);
  modport cnt (input step, input restart, input reload_val, output tick);
endinterface

// [verilog/stage_counter.sv]
// Purpose: reloadable down counter, one tick per reload_val steps
// Assumes: reload_val nonzero while stepping
// Notes:   restart reloads at once and drops any pending count
`timescale 1ns/100ps
module stage_counter
  import baud_gen_pkg::*;
#(
  parameter int W = DIV_W
)(
  input  wire logic clk_sys_i,   // system clock
  input  wire logic rst_i,       // sync reset, high
  stage_if.cnt      port_if      // step in, tick out
);

  logic [W-1:0] count_ff;
  logic         tick_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || port_if.restart)
    begin
      count_ff <= port_if.reload_val[W-1:0];
    end
    else if (port_if.step)
    begin
      if (count_ff <= W'(1))
      begin
        count_ff <= port_if.reload_val[W-1:0];
      end
      else
      begin
        count_ff <= count_ff - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || port_if.restart)
    begin
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= port_if.step && (count_ff <= W'(1));
    end
  end

  assign port_if.tick = tick_ff;

endmodule // stage_counter

// [verilog/bit_rate_divider.sv]
// Purpose: programmable bit rate divider for a serial port
// Assumes: input clock is the reference clock; plain register port
// Notes:   bit period = divisor * 2^(M-1) * (16 - select + fraction) clocks
//
// Contract
// - baud rate is input clock over divisor times prescaler; divisor = low + 256*high.
// - prescaler is two to the exponent minus one times sample count plus fraction.
// - sample count is sixteen minus the sample select value, valid 0h to Ch.
// - exponent comes straight from its register; only 01h and 02h are supported.
// - fraction comes straight from its register, values 0h to 7h.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module bit_rate_divider
  import baud_gen_pkg::*;
(
  input  wire logic              clk_sys_i,     // reference clock, 100 MHz
  input  wire logic              rst_i,         // sync reset, high
  input  wire logic [ADDR_W-1:0] addr_i,        // register index
  input  wire logic [DATA_W-1:0] wdata_i,       // write data
  input  wire logic              wr_i,          // write strobe
  input  wire logic              rd_i,          // read strobe
  output logic      [DATA_W-1:0] rdata_o,       // read data, cycle after rd_i
  output logic                   sample_tick_o, // one per divisor*2^(M-1) clocks
  output logic                   baud_tick_o    // one per bit period
);

  ////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0]        divisor_low_byte_ff;
  logic [7:0]        divisor_high_byte_ff;
  logic [3:0]        sample_clock_select_ff;
  logic [7:0]        prescale_exponent_ff;
  logic [2:0]        prescale_fraction_ff;
  logic              enable_ff;
  logic [7:0]        baud_count_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              restart_ff;

  function automatic logic is_wr(input logic [ADDR_W-1:0] ofs);
    is_wr = wr_i && (addr_i == ofs);
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      divisor_low_byte_ff  <= RST_DIV_LOW;
      divisor_high_byte_ff <= RST_DIV_HIGH;
    end
    else
    begin
      if (is_wr(OFS_DIV_LOW))
      begin
        divisor_low_byte_ff <= wdata_i;
      end
      if (is_wr(OFS_DIV_HIGH))
      begin
        divisor_high_byte_ff <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sample_clock_select_ff <= RST_SAMPLE_SEL;
    end
    else if (is_wr(OFS_SAMPLE_SEL))
    begin
      sample_clock_select_ff <= wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prescale_exponent_ff <= RST_PRE_EXP;
    end
    else if (is_wr(OFS_PRE_EXP))
    begin
      prescale_exponent_ff <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prescale_fraction_ff <= RST_PRE_FRAC;
    end
    else if (is_wr(OFS_PRE_FRAC))
    begin
      prescale_fraction_ff <= wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      enable_ff <= RST_ENABLE;
    end
    else if (is_wr(OFS_CONTROL))
    begin
      enable_ff <= wdata_i[CTL_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      restart_ff <= 1'b1;
    end
    else
    begin
      restart_ff <= wr_i && (addr_i <= OFS_CONTROL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate arithmetic

  logic [DIV_W-1:0] divisor;
  logic [4:0]       sample_count;
  logic [4:0]       sample_plus_frac;
  logic [DIV_W-1:0] exp_factor;
  logic             sel_bad;
  logic             exp_bad;
  logic             zero_bad;
  logic             running;

  assign divisor = (DIV_W'(divisor_high_byte_ff) << DIV_HIGH_SHIFT)
                 | DIV_W'(divisor_low_byte_ff);

  assign sample_count = SAMPLE_BASE - {1'b0, sample_clock_select_ff};

  assign sample_plus_frac = sample_count + {2'b00, prescale_fraction_ff};

  assign exp_factor = (prescale_exponent_ff == PRE_EXP_TWO) ? DIV_W'(2) : DIV_W'(1);

  assign sel_bad  = sample_clock_select_ff > SAMPLE_SEL_MAX;
  assign exp_bad  = (prescale_exponent_ff != PRE_EXP_ONE)
                 && (prescale_exponent_ff != PRE_EXP_TWO);
  assign zero_bad = (divisor == '0) || (sample_plus_frac == 5'h00);
  assign running  = enable_ff && !zero_bad;

  ////////////////////////////////////////////////////////////////////////
  // divider chain: divisor, then exponent, then sample count

  stage_if stage [NUM_STAGES] ();

  logic [DIV_W-1:0] reload_tab [NUM_STAGES];
  logic             step_tab   [NUM_STAGES];

  assign reload_tab[STG_DIVISOR]  = divisor;
  assign reload_tab[STG_EXPONENT] = exp_factor;
  assign reload_tab[STG_SAMPLE]   = DIV_W'(sample_plus_frac);

  assign step_tab[STG_DIVISOR]  = running;
  assign step_tab[STG_EXPONENT] = stage[STG_DIVISOR].tick;
  assign step_tab[STG_SAMPLE]   = stage[STG_EXPONENT].tick;

  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++)
    begin : g_stage
      assign stage[g].step       = step_tab[g] && running;
      assign stage[g].restart    = restart_ff;
      assign stage[g].reload_val = reload_tab[g];

      stage_counter #(
        .W (DIV_W)
      ) u_stage (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .port_if   (stage[g])
      );
    end
  endgenerate

  assign sample_tick_o = stage[STG_EXPONENT].tick;
  assign baud_tick_o   = stage[STG_SAMPLE].tick;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || restart_ff)
    begin
      baud_count_ff <= 8'h00;
    end
    else if (stage[STG_SAMPLE].tick)
    begin
      baud_count_ff <= baud_count_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  logic [DATA_W-1:0] status;

  always_comb
  begin
    status                = '0;
    status[STS_RUN_BIT]   = running;
    status[STS_SEL_BIT]   = sel_bad;
    status[STS_EXP_BIT]   = exp_bad;
    status[STS_ZERO_BIT]  = zero_bad;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= '0;
    end
    else if (rd_i)
    begin
      case (addr_i)
        OFS_DIV_LOW:    rdata_ff <= divisor_low_byte_ff;
        OFS_DIV_HIGH:   rdata_ff <= divisor_high_byte_ff;
        OFS_SAMPLE_SEL: rdata_ff <= {4'h0, sample_clock_select_ff};
        OFS_PRE_EXP:    rdata_ff <= prescale_exponent_ff;
        OFS_PRE_FRAC:   rdata_ff <= {5'h00, prescale_fraction_ff};
        OFS_CONTROL:    rdata_ff <= {7'h00, enable_ff};
        OFS_STATUS:     rdata_ff <= status;
        OFS_BAUD_COUNT: rdata_ff <= baud_count_ff;
        default:        rdata_ff <= '0;
      endcase
    end
    else
    begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;

endmodule // bit_rate_divider

// [tb/bit_rate_divider_props.sv]
// Purpose: port-level checker for bit_rate_divider
// Assumes: register writes are mirrored from the port
// Notes:   the first ticks after a restart are not timed
`timescale 1ns/100ps
module bit_rate_divider_props
  import baud_gen_pkg::*;
(
  input wire logic              clk_sys_i,     // clock
  input wire logic              rst_i,         // reset
  input wire logic [ADDR_W-1:0] addr_i,        // index
  input wire logic [DATA_W-1:0] wdata_i,       // write data
  input wire logic              wr_i,          // write strobe
  input wire logic              rd_i,          // read strobe
  input wire logic [DATA_W-1:0] rdata_o,       // read data
  input wire logic              sample_tick_o, // sample tick
  input wire logic              baud_tick_o    // baud tick
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  sh_ff [6];
  logic        wr1_ff;
  logic        bseen_ff;
  logic        sseen_ff;
  logic [31:0] bcnt_ff;
  logic [31:0] scnt_ff;
  logic [31:0] dx;
  logic [31:0] bper;
  logic        rate_wr;
  logic        off;
  ////////////////////////////////////////////////////////////////
  assign rate_wr = wr_i && addr_i <= OFS_CONTROL;
  assign dx      = {16'h0, sh_ff[1], sh_ff[0]} << (sh_ff[3] == PRE_EXP_TWO);
  assign bper    = dx * (32'h10 - 32'(sh_ff[2][3:0]) + 32'(sh_ff[4][2:0]));
  assign off     = !sh_ff[5][0] || dx == 32'h0;
  // mirror of the rate fields
  always_ff @(posedge clk_sys_i)
    if (rst_i)
      sh_ff <= '{RST_DIV_LOW, RST_DIV_HIGH, 8'(RST_SAMPLE_SEL), RST_PRE_EXP,
                 8'(RST_PRE_FRAC), 8'(RST_ENABLE)};
    else if (rate_wr)
      sh_ff[addr_i] <= wdata_i;
  always_ff @(posedge clk_sys_i)
    wr1_ff <= rate_wr && !rst_i;
  // period counters, timed only once a restart has settled
  always_ff @(posedge clk_sys_i)
    if (rst_i || rate_wr || wr1_ff)
      bseen_ff <= 1'b0;
    else if (baud_tick_o)
      bseen_ff <= 1'b1;
  always_ff @(posedge clk_sys_i)
    if (rst_i || rate_wr || wr1_ff)
      sseen_ff <= 1'b0;
    else if (sample_tick_o)
      sseen_ff <= 1'b1;
  always_ff @(posedge clk_sys_i)
    bcnt_ff <= (rst_i || baud_tick_o) ? 32'h1 : bcnt_ff + 32'h1;
  always_ff @(posedge clk_sys_i)
    scnt_ff <= (rst_i || sample_tick_o) ? 32'h1 : scnt_ff + 32'h1;
  ////////////////////////////////////////////////////////////////
  baud_period_a: assert property (
    baud_tick_o && bseen_ff |-> bcnt_ff == bper) else $error("baud period wrong");
  sample_period_a: assert property (
    sample_tick_o && sseen_ff |-> scnt_ff == dx) else $error("sample period wrong");
  baud_after_sample_a: assert property (
    baud_tick_o |-> $past(sample_tick_o)) else $error("baud tick without sample tick");
  tick_gap_a: assert property (
    baud_tick_o && sh_ff[2][3:0] <= SAMPLE_SEL_MAX |=> !baud_tick_o)
    else $error("baud tick too long");
  reg_readback_a: assert property (
    rd_i && (addr_i < 3'h2 || addr_i == OFS_PRE_EXP) |=> rdata_o == sh_ff[$past(addr_i)])
    else $error("read data wrong");
  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
  restart_clear_a: assert property (
    rate_wr |-> ##2 !baud_tick_o && !sample_tick_o) else $error("tick after restart");
  stopped_quiet_a: assert property (
    off && $past(off) && $past(off, 2) |-> !baud_tick_o && !sample_tick_o)
    else $error("tick while stopped");
endmodule // bit_rate_divider_props

bind bit_rate_divider bit_rate_divider_props u_props (.clk_sys_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_tick_o, .baud_tick_o);

// [tb/tb_top.sv]
// Purpose: self-checking bench for bit_rate_divider
// Assumes: reset values from the package
// Notes:   ordinary rate settings are table rows
`timescale 1ns/100ps
module tb_top
  import baud_gen_pkg::*;
;
  typedef struct {logic [7:0] lo, hi, sel, ex, fr; logic [15:0] s, bp;} row_t;
  logic              clk_sys_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic [ADDR_W-1:0] addr_i    = 3'h0;
  logic [DATA_W-1:0] wdata_i   = 8'h00;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic              sample_tick_o;
  logic              baud_tick_o;
  int                miscompares = 0;
  int                num_checks  = 0;
  int                n;
  int                ns;
  int                c;
  row_t rows [5] = '{
    '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 16'h10, 16'h10},
    '{8'h03, 8'h00, 8'h0C, 8'h02, 8'h07, 16'h0B, 16'h42},
    '{8'h02, 8'h00, 8'h04, 8'h01, 8'h03, 16'h0F, 16'h1E},
    '{8'h05, 8'h00, 8'h0A, 8'h02, 8'h05, 16'h0B, 16'h6E},
    '{8'h00, 8'h01, 8'h0C, 8'h01, 8'h00, 16'h04, 16'h400}};

  bit_rate_divider u_bit_rate_divider (.clk_sys_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sample_tick_o, .baud_tick_o);
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // cycles up to the next baud tick, and sample ticks on the way
  task automatic nxt();
    n  = 0;
    ns = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1 n++;
      if (sample_tick_o === 1'b1)
        ns++;
    end
    while (baud_tick_o !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic quiet();
    c = 0;
    repeat (300)
    begin
      @(posedge clk_sys_i);
      #1 if (baud_tick_o !== 1'b0 || sample_tick_o !== 1'b0)
        c++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(OFS_DIV_LOW, RST_DIV_LOW);
    rd(OFS_DIV_HIGH, RST_DIV_HIGH);
    rd(OFS_SAMPLE_SEL, 8'(RST_SAMPLE_SEL));
    rd(OFS_PRE_EXP, RST_PRE_EXP);
    rd(OFS_PRE_FRAC, 8'(RST_PRE_FRAC));
    wr(OFS_STATUS, 8'hFE);
    rd(OFS_STATUS, 8'h01);
    foreach (rows[i])
    begin
      wr(OFS_DIV_LOW, rows[i].lo);
      wr(OFS_DIV_HIGH, rows[i].hi);
      wr(OFS_SAMPLE_SEL, rows[i].sel);
      wr(OFS_PRE_EXP, rows[i].ex);
      wr(OFS_PRE_FRAC, rows[i].fr);
      rd(OFS_DIV_HIGH, rows[i].hi);
      repeat (3) nxt();
      chk(n, 32'(rows[i].bp));
      chk(ns, 32'(rows[i].s));
    end
    // rewrite in mid-period restarts the full count
    nxt();
    repeat (500) @(posedge clk_sys_i);
    wr(OFS_DIV_HIGH, 8'h01);
    nxt();
    chk(n > 1017 && n < 1031, 32'h1);
    wr(OFS_DIV_HIGH, 8'h00);
    quiet();
    chk(c, 32'h0);
    rd(OFS_STATUS, 8'h08);
    wr(OFS_DIV_LOW, 8'h01);
    wr(OFS_CONTROL, 8'h00);
    quiet();
    chk(c, 32'h0);
    wr(OFS_CONTROL, 8'h01);
    repeat (3) nxt();
    chk(n, 32'h4);
    chk(ns, 32'h4);
    rd(OFS_BAUD_COUNT, 8'h03);
    // unsupported exponent counts as one, select above C still divides
    wr(OFS_PRE_EXP, 8'h03);
    wr(OFS_SAMPLE_SEL, 8'h0D);
    rd(OFS_STATUS, 8'h07);
    repeat (3) nxt();
    chk(n, 32'h3);
    chk(ns, 32'h3);
    // reset in mid-run brings back the reset rates
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(OFS_PRE_EXP, RST_PRE_EXP);
    rd(OFS_STATUS, 8'h01);
    repeat (3) nxt();
    chk(n, 32'h10);
    chk(ns, 32'h10);
    final_report();
  end
endmodule // tb_top
